/* File: include/epio_pkg.sv */
// Constants, register map and carrier types for the eight-pin I/O port.
// Assumes the processor's register port carries 8-bit addresses and data.
`default_nettype none
package epio_pkg;
  localparam int          PIN_CNT         = 8;
  localparam int          MODE_W          = 2;
  // Register addresses; the lower mode register has no printed address
  localparam logic [7:0]  ADDR_UPPER_MODE = 8'hEA;
  localparam logic [7:0]  ADDR_LOWER_MODE = 8'hEB;
  localparam logic [7:0]  ADDR_PIN_DATA   = 8'hF1;
  localparam logic [7:0]  ADDR_PULLUP_EN  = 8'hF2;
  // Reset values
  localparam logic [7:0]  RST_UPPER_MODE  = 8'hFF;
  localparam logic [7:0]  RST_LOWER_MODE  = 8'h00;
  localparam logic [7:0]  RST_PIN_DATA    = 8'h00;
  localparam logic [7:0]  RST_PULLUP_EN   = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
  // Mode field encodings
  localparam logic [1:0]  MODE_INPUT      = 2'h0;
  localparam logic [1:0]  MODE_OPEN_DRAIN = 2'h1;
  localparam logic [1:0]  MODE_PUSH_PULL  = 2'h2;
  localparam logic [1:0]  MODE_INPUT_PU   = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } epio_reg_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } epio_pad_t;
endpackage
`default_nettype wire

/* File: verification/epio_board.sv */
// Board model: pin levels from port drive, board drive and pull-ups.
// Where the bench and the port both drive a pin, the port's level wins.
`default_nettype none
module epio_board (
  input  wire logic                sys_clk,
  input  wire epio_pkg::epio_pad_t pad,
  input  wire logic [7:0]          ext_oe,
  input  wire logic [7:0]          ext_val,
  output logic [7:0]               pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] flt_r = 8'h55;
  // Undriven pins without pull-up wander every cycle
  always @(posedge sys_clk) flt_r <= ~flt_r;
  assign pad_in = (pad.oe & pad.out) | (~pad.oe & ((ext_oe & ext_val) | (~ext_oe & (pad.pu | flt_r))));
endmodule
`default_nettype wire

/* File: verification/epio_port_chk.sv */
// Port checker: register reads, pad drive per mode, pin sync.
// Assumes it is bound to epio_port with one clock and a sync reset.
`default_nettype none
module epio_port_chk #(
  parameter int PIN_CNT = 8
) (
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  input wire epio_pkg::epio_reg_req_t reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire logic [PIN_CNT-1:0]      pad_in,
  input wire epio_pkg::epio_pad_t     pad,
  input wire logic [3:0]              analog_input_en,
  input wire logic                    serial_rx_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] up_r, lo_r, pe_r, m1, m0, ana, pp_m, out_m, ipu_m, in_m;
  logic       hit;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      up_r <= 8'hFF;
      lo_r <= 8'h00;
      pe_r <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == 8'hEA) up_r <= reg_req.wdata;
      if (reg_req.addr == epio_pkg::ADDR_LOWER_MODE) lo_r <= reg_req.wdata;
      if (reg_req.addr == 8'hF2) pe_r <= reg_req.wdata;
    end
  end
  // Upper register holds pins 7..4 from the top bit pair down
  assign m1 = {up_r[7], up_r[5], up_r[3], up_r[1], lo_r[7], lo_r[5], lo_r[3], lo_r[1]};
  assign m0 = {up_r[6], up_r[4], up_r[2], up_r[0], lo_r[6], lo_r[4], lo_r[2], lo_r[0]};
  assign ana = {4'h0, analog_input_en[0], analog_input_en[1], analog_input_en[2], analog_input_en[3]};
  assign pp_m = m1 & ~m0 & ~ana;
  assign out_m = (m1 ^ m0) & ~ana;
  assign ipu_m = m1 & m0 & ~ana;
  assign in_m = ~(m1 ^ m0) | ana;
  assign hit = reg_req.addr inside {8'hEA, epio_pkg::ADDR_LOWER_MODE, 8'hF1, 8'hF2};
  property p_rst_pads; $rose(nrst) && ana == 8'h00 |=> pad.oe == 8'h00 && pad.pu == 8'hF0; endproperty
  a_rst_pads: assert property (p_rst_pads) else $error("pad state after reset");
  property p_unmapped; reg_req.rd && !hit |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !reg_req.rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rd_pe; reg_req.rd && reg_req.addr == 8'hF2 |=> reg_rdata == $past(pe_r); endproperty
  a_rd_pe: assert property (p_rd_pe) else $error("pull-up enable readback");
  property p_in_oe; (pad.oe & $past(in_m)) == 8'h00; endproperty
  a_in_oe: assert property (p_in_oe) else $error("input pin driven");
  property p_pp; $past(nrst) |-> (pad.oe & $past(pp_m)) == $past(pp_m); endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin not driven");
  property p_pu; $past(nrst) |-> ((pad.pu ^ $past(pe_r)) & $past(out_m)) == 8'h00
    && (pad.pu & $past(ipu_m)) == $past(ipu_m); endproperty
  a_pu: assert property (p_pu) else $error("pull-up wrong");
  property p_rx; $past(nrst) && $past(nrst, 2) |-> serial_rx_line == $past(pad_in[2], 2); endproperty
  a_rx: assert property (p_rx) else $error("serial receive level");
  c_pp: cover property (|pp_m && |pad.oe);
  c_wr: cover property (reg_req.wr && reg_req.addr == 8'hF1);
  c_unmapped: cover property (reg_req.rd && !hit);
endmodule
bind epio_port epio_port_chk #(.PIN_CNT(PIN_CNT)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad(pad),
  .analog_input_en(analog_input_en), .serial_rx_line(serial_rx_line)
);
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the eight-pin port with a board model.
// Assumes the port checker is bound in its own file.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    sys_clk, nrst, rx;
  epio_pkg::epio_reg_req_t req;
  epio_pkg::epio_pad_t     pad, e;
  logic [7:0]              pad_in, reg_rdata, ext_oe, ext_val, up, lo, pe, dat, om, v, an, ae, av;
  logic [21:0]             pv;
  int                      mismatches, comparisons;
  epio_port dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_req(req), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad(pad),
    .analog_input_en(pv[3:0]), .timer_b_pwm_out(pv[4]), .timer_b_pwm_en(pv[5]), .buzzer_out(pv[6]),
    .buzzer_en(pv[7]), .serial_rx_line(rx), .serial_tx_line(pv[8]), .serial_tx_en(pv[9]),
    .timer_c_out(pv[10]), .timer_c_out_en(pv[11]), .timer_c_pwm_out(pv[12]), .timer_c_pwm_en(pv[13]),
    .lcd_common_line_a(pv[14]), .lcd_common_line_b(pv[15]), .lcd_common_line_c(pv[16]),
    .lcd_common_line_d(pv[17]), .lcd_common_en(pv[21:18])
  );
  epio_board board (.sys_clk(sys_clk), .pad(pad), .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in));
  assign an = {4'h0, pv[0], pv[1], pv[2], pv[3]};
  assign ae = {pv[18], pv[19], pv[20], pv[21] | pv[11] | pv[13], pv[9], 1'h0, pv[7], pv[5]};
  assign av = {pv[14], pv[15], pv[16], pv[11] ? pv[10] : (pv[13] ? pv[12] : pv[17]), pv[8], 1'h0, pv[6], pv[4]};
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge sys_clk) req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk) req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge sys_clk) req = '0;
    d = reg_rdata;
  endtask
  function automatic epio_pkg::epio_pad_t pexp(input logic [15:0] mv, input logic [7:0] dv, input logic [7:0] pu,
                                               output logic [7:0] m);
    epio_pkg::epio_pad_t p;
    for (int i = 0; i < 8; i++) begin
      m[i] = mv[2*i+1] ^ mv[2*i];
      p.oe[i] = !an[i] && (mv[2*i+:2] == 2'h2 || (mv[2*i+:2] == 2'h1 && !dv[i]));
      p.out[i] = mv[2*i+:2] == 2'h2 && dv[i];
      p.pu[i] = !an[i] && (mv[2*i+:2] == 2'h3 || (m[i] && pu[i]));
    end
    return p;
  endfunction
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial begin
    {nrst, req, pv, ext_oe, ext_val} = {1'h0, 18'h0_0000, 22'h00_0000, 8'h0F, 8'h5A};
    void'($urandom(32'h1f13));
    repeat (12) @(negedge sys_clk);
    nrst = 1'h1;
    repeat (2) @(negedge sys_clk);
    chk(pad.pu, 8'hF0);
    chk(pad.oe, 8'h00);
    wr(8'hEC, 8'hA5);
    rd(8'hEC, v);
    chk(v, 8'h00);
    rd(8'hEA, v);
    chk(v, 8'hFF);
    rd(8'hF1, v);
    chk(v, {4'hF, ext_val[3:0]});
    for (int it = 0; it < 24; it++) begin
      {up, lo} = (it == 0) ? 16'h1BE4 : 16'($urandom);
      {pe, dat} = 16'($urandom);
      wr(8'hEA, up);
      wr(epio_pkg::ADDR_LOWER_MODE, lo);
      wr(8'hF2, pe);
      wr(8'hF1, dat);
      pv = 22'($urandom);
      @(negedge sys_clk);
      e = pexp({up, lo}, (ae & av) | (~ae & dat), pe, om);
      {ext_oe, ext_val} = {~om, 8'($urandom)};
      repeat (3) @(negedge sys_clk);
      chk(pad.oe, e.oe);
      chk(pad.pu, e.pu);
      chk(pad.out & om, e.out & om);
      if (!om[2]) chk({7'h00, rx}, {7'h00, ext_val[2]});
      rd(8'hF1, v);
      chk(v, (dat & om) | (ext_val & ~om));
      rd(epio_pkg::ADDR_LOWER_MODE, v);
      chk(v, lo);
      rd(8'hEA, v);
      chk(v, up);
      rd(8'hF2, v);
      chk(v, pe);
    end
    // Reset again from a busy state
    {nrst, pv} = {1'h0, 22'h00_0000};
    repeat (3) @(negedge sys_clk);
    nrst = 1'h1;
    repeat (2) @(negedge sys_clk);
    chk(pad.pu, 8'hF0);
    chk(pad.oe, 8'h00);
    rd(8'hEA, v);
    chk(v, 8'hFF);
    rd(epio_pkg::ADDR_LOWER_MODE, v);
    chk(v, 8'h00);
    rd(8'hF2, v);
    chk(v, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire

/* File: verilog/epio_pin.sv */
// One pin cell: input synchroniser and registered pad drive.
// Assumes mode, data and alternate-function inputs come from sys_clk logic.
`default_nettype none
module epio_pin (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] mode,
  input  wire logic       data_bit,
  input  wire logic       out_pu_en,
  input  wire logic       alt_en,
  input  wire logic       alt_val,
  input  wire logic       analog_en,
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pad_pu,
  output logic            level
);
  logic meta_r;
  logic level_r;
  logic pad_out_r;
  logic pad_oe_r;
  logic pad_pu_r;

  wire is_od    = (mode == epio_pkg::MODE_OPEN_DRAIN);
  wire is_pp    = (mode == epio_pkg::MODE_PUSH_PULL);
  wire is_out   = is_od | is_pp;
  // A peripheral only takes the pin when software also chose an output mode
  wire drive_v  = (alt_en & is_out) ? alt_val : data_bit; // RULE7
  // Open drain pulls low on 0 and releases on 1
  wire oe_nxt   = ~analog_en & (is_pp | (is_od & ~drive_v)); // RULE9
  wire out_nxt  = is_pp & drive_v; // RULE2
  wire pu_nxt   = ~analog_en & ((mode == epio_pkg::MODE_INPUT_PU) | (is_out & out_pu_en)); // RULE6

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_r    <= 1'b0;
      level_r   <= 1'b0;
      pad_out_r <= 1'b0;
      pad_oe_r  <= 1'b0;
      pad_pu_r  <= 1'b0;
    end else begin
      meta_r    <= pad_in;
      level_r   <= meta_r;
      pad_out_r <= out_nxt;
      pad_oe_r  <= oe_nxt;
      pad_pu_r  <= pu_nxt;
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe  = pad_oe_r;
  assign pad_pu  = pad_pu_r;
  assign level   = level_r;
endmodule
`default_nettype wire

/* File: verilog/epio_port.sv */
// Eight-pin general-purpose I/O port with per-pin mode control.
// Assumes a single-cycle register port from the core on sys_clk and
// peripherals on the same clock; pads are resolved outside this block.
// Pad out, oe and pu leave flip-flops; each pad_in bit is synchronised per pin.
//
// Summary of operation
// RULE1: Eight pins are read and written through one 8-bit data register at F1h.
// RULE2: Each pin's two-bit mode selects CMOS input, open drain, push-pull or input with pull-up.
// RULE3: The upper mode register at EAh holds pins 7 to 4 from the top bit pair down.
// RULE4: The upper mode register resets to FFh so pins 7 to 4 start as inputs with pull-up.
// RULE5: The lower mode register holds pins 3 to 0 from the top pair down and resets to 00h.
// RULE6: The register at F2h enables each pin's pull-up in output mode and resets to zero.
// RULE7: Pins carry alternate functions: analog, timer, buzzer, serial and LCD common lines.
// RULE8: Software enabling an alternate function must also enable it in the peripheral itself.
// RULE9: Open drain drives low on 0 and releases on 1; input pins read their synchronised level.
`default_nettype none
module epio_port #(
  parameter int PIN_CNT = epio_pkg::PIN_CNT
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // Core register port
  input  wire epio_pkg::epio_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  // Pads
  input  wire logic [PIN_CNT-1:0]    pad_in,
  output epio_pkg::epio_pad_t        pad,
  // Peripherals on pins 0 to 3
  input  wire logic [3:0]            analog_input_en,
  input  wire logic                  timer_b_pwm_out,
  input  wire logic                  timer_b_pwm_en,
  input  wire logic                  buzzer_out,
  input  wire logic                  buzzer_en,
  output logic                       serial_rx_line,
  input  wire logic                  serial_tx_line,
  input  wire logic                  serial_tx_en,
  // Peripherals on pins 4 to 7
  input  wire logic                  timer_c_out,
  input  wire logic                  timer_c_out_en,
  input  wire logic                  timer_c_pwm_out,
  input  wire logic                  timer_c_pwm_en,
  input  wire logic                  lcd_common_line_a,
  input  wire logic                  lcd_common_line_b,
  input  wire logic                  lcd_common_line_c,
  input  wire logic                  lcd_common_line_d,
  input  wire logic [3:0]            lcd_common_en
);
  logic [7:0]         upper_pin_mode_ctrl_r;
  logic [7:0]         lower_pin_mode_ctrl_r;
  logic [7:0]         port_one_pin_data_r;
  logic [7:0]         output_pullup_enable_r;
  logic [7:0]         reg_rdata_r;
  logic [PIN_CNT-1:0] level;
  logic [PIN_CNT-1:0] pad_out;
  logic [PIN_CNT-1:0] pad_oe;
  logic [PIN_CNT-1:0] pad_pu;

  // Mode field of one pin out of the joined mode registers
  function automatic logic [1:0] pin_mode(input logic [15:0] modes, input int idx);
    pin_mode = modes[idx*epio_pkg::MODE_W +: epio_pkg::MODE_W];
  endfunction

  function automatic logic is_output(input logic [1:0] m);
    is_output = (m == epio_pkg::MODE_OPEN_DRAIN) || (m == epio_pkg::MODE_PUSH_PULL);
  endfunction

  // Upper register at the top so pin 7 sits in bits [15:14]
  wire [15:0] all_modes = {upper_pin_mode_ctrl_r, lower_pin_mode_ctrl_r}; // RULE3 RULE5

  // Mode field of each pin
  logic [1:0] pin_modes [PIN_CNT];
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      pin_modes[i] = pin_mode(all_modes, i);
    end
  end

  // Address decode; the lower mode register address is a local choice
  wire hit_upper  = (reg_req.addr == epio_pkg::ADDR_UPPER_MODE);
  wire hit_lower  = (reg_req.addr == epio_pkg::ADDR_LOWER_MODE);
  wire hit_data   = (reg_req.addr == epio_pkg::ADDR_PIN_DATA);
  wire hit_pullup = (reg_req.addr == epio_pkg::ADDR_PULLUP_EN);

  // Write strobes; an unmapped address leaves every register alone
  wire wr_upper  = reg_req.wr & hit_upper;
  wire wr_lower  = reg_req.wr & hit_lower;
  wire wr_data   = reg_req.wr & hit_data;
  wire wr_pullup = reg_req.wr & hit_pullup;

  // Pin 4 is shared: timer output first, then timer PWM, then the LCD common line
  wire pin4_timer = timer_c_out_en | timer_c_pwm_en;
  wire pin4_tval  = timer_c_out_en ? timer_c_out : timer_c_pwm_out;

  // Peripheral enables per pin; pin 2 only receives and never takes a drive
  wire alt_en_p0 = timer_b_pwm_en;
  wire alt_en_p1 = buzzer_en;
  wire alt_en_p2 = 1'h0;
  wire alt_en_p3 = serial_tx_en;
  wire alt_en_p4 = pin4_timer | lcd_common_en[3];
  wire alt_en_p5 = lcd_common_en[2];
  wire alt_en_p6 = lcd_common_en[1];
  wire alt_en_p7 = lcd_common_en[0];

  // Peripheral drive values per pin
  wire alt_val_p0 = timer_b_pwm_out;
  wire alt_val_p1 = buzzer_out;
  wire alt_val_p2 = 1'h0;
  wire alt_val_p3 = serial_tx_line;
  wire alt_val_p4 = pin4_timer ? pin4_tval : lcd_common_line_d;
  wire alt_val_p5 = lcd_common_line_c;
  wire alt_val_p6 = lcd_common_line_b;
  wire alt_val_p7 = lcd_common_line_a;

  // A function only reaches its pin with the peripheral's own enable as well
  wire [7:0] alt_en  = {alt_en_p7, alt_en_p6, alt_en_p5, alt_en_p4,
                        alt_en_p3, alt_en_p2, alt_en_p1, alt_en_p0}; // RULE7 RULE8
  wire [7:0] alt_val = {alt_val_p7, alt_val_p6, alt_val_p5, alt_val_p4,
                        alt_val_p3, alt_val_p2, alt_val_p1, alt_val_p0}; // RULE7

  // Analog channel d sits on pin 0 and channel a on pin 3; upper pins have none
  wire [3:0] analog_low = {analog_input_en[0], analog_input_en[1],
                           analog_input_en[2], analog_input_en[3]};
  wire [7:0] analog_en  = {4'h0, analog_low}; // RULE7

  // Pins in an output mode
  logic [7:0] out_mode;
  always_comb begin
    out_mode = '0;
    for (int i = 0; i < PIN_CNT; i++) begin
      out_mode[i] = is_output(pin_modes[i]); // RULE2
    end
  end

  // Data read: output pins return the latch, input pins the synchronised level
  wire [7:0] data_view = (port_one_pin_data_r & out_mode) | (level & ~out_mode); // RULE9 RULE1

  // Unmapped reads return zero and flag nothing
  wire [7:0] rdata_nxt = hit_upper  ? upper_pin_mode_ctrl_r :
                         hit_lower  ? lower_pin_mode_ctrl_r :
                         hit_data   ? data_view :
                         hit_pullup ? output_pullup_enable_r :
                                      epio_pkg::READ_UNMAPPED;

  wire [7:0] upper_nxt  = wr_upper  ? reg_req.wdata : upper_pin_mode_ctrl_r;
  wire [7:0] lower_nxt  = wr_lower  ? reg_req.wdata : lower_pin_mode_ctrl_r;
  wire [7:0] data_nxt   = wr_data   ? reg_req.wdata : port_one_pin_data_r;
  wire [7:0] pullup_nxt = wr_pullup ? reg_req.wdata : output_pullup_enable_r;
  // Read data only moves on a read and holds otherwise
  wire [7:0] reg_rdata_nxt = reg_req.rd ? rdata_nxt : reg_rdata_r;

  // Upper mode register: pins 7 to 4 come out of reset as inputs with pull-up
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      upper_pin_mode_ctrl_r <= epio_pkg::RST_UPPER_MODE; // RULE4
    end else begin
      upper_pin_mode_ctrl_r <= upper_nxt; // RULE3
    end
  end

  // Lower mode register: pins 3 to 0 come out of reset as plain inputs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lower_pin_mode_ctrl_r <= epio_pkg::RST_LOWER_MODE; // RULE5
    end else begin
      lower_pin_mode_ctrl_r <= lower_nxt; // RULE5
    end
  end

  // Output latch of the data register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port_one_pin_data_r <= epio_pkg::RST_PIN_DATA;
    end else begin
      port_one_pin_data_r <= data_nxt; // RULE1
    end
  end

  // Pull-up enables for pins in an output mode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      output_pullup_enable_r <= epio_pkg::RST_PULLUP_EN; // RULE6
    end else begin
      output_pullup_enable_r <= pullup_nxt; // RULE6
    end
  end

  // Read data register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata_r <= epio_pkg::READ_UNMAPPED;
    end else begin
      reg_rdata_r <= reg_rdata_nxt; // RULE1
    end
  end

  for (genvar g = 0; g < PIN_CNT; g++) begin : g_pin
    epio_pin u_pin (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .mode      (pin_modes[g]), // RULE2
      .data_bit  (port_one_pin_data_r[g]),
      .out_pu_en (output_pullup_enable_r[g]),
      .alt_en    (alt_en[g]),
      .alt_val   (alt_val[g]),
      .analog_en (analog_en[g]),
      .pad_in    (pad_in[g]),
      .pad_out   (pad_out[g]),
      .pad_oe    (pad_oe[g]),
      .pad_pu    (pad_pu[g]),
      .level     (level[g])
    );
  end

  assign pad.out        = pad_out;
  assign pad.oe         = pad_oe;
  assign pad.pu         = pad_pu;
  assign reg_rdata      = reg_rdata_r;
  assign serial_rx_line = level[2];
endmodule
`default_nettype wire
